// [pcg_pkg.sv]
// Purpose: Shared constants and types of the clock generator control block.
// Assumes: Registers are reached over AHB-Lite with one word per register.
// Notes:   Byte address of each register is four times its index.
package pcg_pkg;

  // Register indices and their byte addresses on the bus.
  localparam logic [7:0] PCG_IDX_CTRL = 8'h1C;
  localparam logic [7:0] PCG_IDX_BW   = 8'h1D;
  localparam logic [7:0] PCG_IDX_PROG = 8'h1E;
  localparam logic [9:0] PCG_ADDR_CTRL = {PCG_IDX_CTRL, 2'b00};
  localparam logic [9:0] PCG_ADDR_BW   = {PCG_IDX_BW, 2'b00};
  localparam logic [9:0] PCG_ADDR_PROG = {PCG_IDX_PROG, 2'b00};

  // Field positions of the control register.
  localparam int PCG_CTRL_IE   = 7;
  localparam int PCG_CTRL_IF   = 6;
  localparam int PCG_CTRL_PON  = 5;
  localparam int PCG_CTRL_BSS  = 4;
  localparam int PCG_CTRL_VSEL = 0;
  // Field positions of the bandwidth control register.
  localparam int PCG_BW_AUTO = 7;
  localparam int PCG_BW_LOCK = 6;
  localparam int PCG_BW_TRK  = 5;

  // Reset values.
  localparam logic [7:0] PCG_CTRL_RST = 8'h00;
  localparam logic [7:0] PCG_BW_RST   = 8'h00;
  localparam logic [7:0] PCG_PROG_RST = 8'h00;

  // Transition control waits this many edges of each source clock.
  localparam logic [1:0] PCG_SWITCH_EDGES = 2'h3;

  // Nominal VCO frequency in Hz; center of range is L times this.
  localparam int PCG_FNOM_HZ  = 4915200;

  // AHB-Lite transfer type that starts a transfer.
  localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;

  // Rising edges seen in the current cycle on the sampled clocks.
  typedef struct packed {
    logic xtal;
    logic vco;
    logic ref_clk;
    logic fb;
  } pcg_edges_t;

  // Lock detector verdict.
  typedef struct packed {
    logic tracking;
    logic locked;
  } pcg_lock_t;

  typedef enum {PCG_SEL_RUN, PCG_SEL_HOLD} pcg_sel_state_t;

endpackage : pcg_pkg

// [pcg_mod_div.sv]
// Purpose: Divides a stream of edge events by a programmable factor.
// Assumes: Edge events are one-cycle pulses on hclk.
// Notes:   A factor of zero divides by one.
module pcg_mod_div #(
  parameter int W = 4
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         edge_in,
  input  wire logic [W-1:0] factor,
  output logic              clk_out,
  output logic              edge_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         clk_d;
  logic         edge_d;
  logic [W-1:0] last;

  // Count input edges; one output edge every factor input edges.
  always_comb begin
    last   = (factor == '0) ? '0 : factor - W'(1);
    cnt_d  = cnt_q;
    edge_d = 1'b0;
    clk_d  = clk_out;
    if (edge_in) begin
      if (cnt_q >= last) begin
        cnt_d  = '0;
        edge_d = 1'b1;
        clk_d  = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
        if (cnt_q + W'(1) >= {1'b0, last[W-1:1]} + W'(1)) begin
          clk_d = 1'b0;
        end
      end
    end else if (last == '0) begin
      // Without division the output pulses once per input edge, so it
      // still shows one rising edge for every edge that comes in.
      clk_d = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= '0;
      clk_out  <= 1'b0;
      edge_out <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      clk_out  <= clk_d;
      edge_out <= edge_d;
    end
  end

endmodule : pcg_mod_div

// [pcg_lock_det.sv]
// Purpose: Frequency lock detector with hysteretic windows.
// Assumes: Reference and feedback edges arrive as one-cycle pulses.
// Notes:   Speed scales with the reference rate, one verdict per window.
module pcg_lock_det #(
  parameter int REF_WIN = 32,
  parameter int TRK_TOL = 2,
  parameter int UNT_TOL = 4,
  parameter int LCK_TOL = 1,
  parameter int UNL_TOL = 3
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              enable,
  input  wire pcg_pkg::pcg_edges_t edges,
  output pcg_pkg::pcg_lock_t     state
);

  logic [7:0] ref_q, ref_d, fb_q, fb_d;
  logic [7:0] diff;
  pcg_pkg::pcg_lock_t state_d;

  // Count feedback edges over a window of reference edges.
  always_comb begin
    ref_d   = ref_q;
    fb_d    = fb_q;
    state_d = state;
    diff    = (fb_q > 8'(REF_WIN)) ? fb_q - 8'(REF_WIN)
                                   : 8'(REF_WIN) - fb_q;
    if (!enable) begin
      ref_d   = '0;
      fb_d    = '0;
      state_d = '0;
    end else begin
      if (edges.fb && fb_q != 8'hFF) begin
        fb_d = fb_q + 8'h01;
      end
      if (edges.ref_clk) begin
        ref_d = ref_q + 8'h01;
        if (ref_q == 8'(REF_WIN - 1)) begin
          ref_d = '0;
          fb_d  = {7'h00, edges.fb};
          // Hysteresis: enter inside the tight window, leave outside
          // the wide one.
          if (diff <= 8'(TRK_TOL)) state_d.tracking = 1'b1;
          else if (diff > 8'(UNT_TOL)) state_d.tracking = 1'b0;
          if (diff <= 8'(LCK_TOL)) state_d.locked = 1'b1;
          else if (diff > 8'(UNL_TOL)) state_d.locked = 1'b0;
        end
      end
    end
  end

  // State registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q <= '0;
      fb_q  <= '0;
      state <= '0;
    end else begin
      ref_q <= ref_d;
      fb_q  <= fb_d;
      state <= state_d;
    end
  end

endmodule : pcg_lock_det

// [pcg_top.sv]
// Purpose: Control logic of the PLL clock generator with AHB-Lite access.
// Assumes: Crystal and VCO clocks arrive as inputs synchronous to hclk.
// Notes:   Analog VCO, loop filter and crystal are outside this block.
//
// Register access over AHB-Lite was chosen for this implementation.
module pcg_top #(
  parameter int REF_WIN = 32,
  parameter int TRK_TOL = 2,
  parameter int UNT_TOL = 4,
  parameter int LCK_TOL = 1,
  parameter int UNL_TOL = 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        oscillator_enable_signal,
  input  wire logic        crystal_amp_input,
  output logic             crystal_amp_output,
  input  wire logic        vco_clock,
  output logic             crystal_clock,
  output logic             reference_clock,
  output logic             final_reference_clock,
  output logic             vco_feedback_clock,
  output logic             base_clock_out,
  output logic             pump_up,
  output logic             pump_down,
  output logic             filter_tracking,
  output logic             vco_enable,
  output logic [3:0]       vco_range,
  output logic             pll_irq
);

  // Register state.
  logic [7:0] ctrl_q, ctrl_d, bw_q, bw_d, prog_q, prog_d;
  logic       det_locked_q, det_locked_d;
  // Bus data phase state.
  logic       wr_pend_q, wr_pend_d;
  logic [9:0] addr_q, addr_d;
  logic [31:0] rdata_d;
  // Clock edge detection.
  logic       xtal_q, xtal_d, vco_q, ref_q, ref_d;
  logic       fbk_clk;
  logic       fb_edge;
  pcg_pkg::pcg_edges_t edges;
  pcg_pkg::pcg_lock_t  det;
  // Derived controls.
  logic       pll_active, auto_mode, lock_vis, trk_eff, want_vco;
  // Base clock selector.
  pcg_pkg::pcg_sel_state_t sel_q, sel_d;
  logic       vsel_q, vsel_d, base_d;
  logic [1:0] xcnt_q, xcnt_d, vcnt_q, vcnt_d;
  // Phase detector.
  logic       up_d, dn_d;

  assign pll_active = ctrl_q[pcg_pkg::PCG_CTRL_PON] && prog_q[3:0] != 4'h0;
  assign auto_mode  = bw_q[pcg_pkg::PCG_BW_AUTO];
  assign lock_vis   = auto_mode && det_locked_q;
  // Tracking when not acquiring or the bit forces it.
  assign trk_eff    = auto_mode ? det.tracking : bw_q[pcg_pkg::PCG_BW_TRK];
  assign want_vco   = ctrl_q[pcg_pkg::PCG_CTRL_BSS] && pll_active;

  // Loop controls to the analog part come from flip-flops, except vco_enable, which is PON ANDed with a nonzero L field.
  assign vco_enable = pll_active;
  assign vco_range  = prog_q[3:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  // Sampled clock edges; the crystal clock only runs while enabled.
  assign edges.xtal    = xtal_d && !xtal_q;
  assign edges.vco     = vco_clock && !vco_q && pll_active;
  assign edges.ref_clk = ref_d && !ref_q;
  assign edges.fb      = fb_edge;

  always_comb begin
    xtal_d = crystal_amp_input && oscillator_enable_signal;
    ref_d  = xtal_q;
  end

  // Oscillator and reference buffer chain.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_q                <= 1'b0;
      vco_q                 <= 1'b0;
      ref_q                 <= 1'b0;
      crystal_clock         <= 1'b0;
      crystal_amp_output    <= 1'b0;
      reference_clock       <= 1'b0;
      final_reference_clock <= 1'b0;
      vco_feedback_clock    <= 1'b0;
    end else begin
      xtal_q                <= xtal_d;
      vco_q                 <= vco_clock;
      ref_q                 <= ref_d;
      crystal_clock         <= xtal_d;
      crystal_amp_output    <= oscillator_enable_signal && !crystal_amp_input;
      reference_clock       <= xtal_q;
      final_reference_clock <= ref_d;
      vco_feedback_clock    <= fbk_clk;
    end
  end

  // Feedback divider on VCO edges by N.
  pcg_mod_div #(
    .W (4)
  ) u_fb_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .edge_in  (edges.vco),
    .factor   (prog_q[7:4]),
    .clk_out  (fbk_clk),
    .edge_out (fb_edge)
  );

  // Frequency comparison for mode and lock decisions.
  pcg_lock_det #(
    .REF_WIN (REF_WIN),
    .TRK_TOL (TRK_TOL),
    .UNT_TOL (UNT_TOL),
    .LCK_TOL (LCK_TOL),
    .UNL_TOL (UNL_TOL)
  ) u_lock (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (pll_active && auto_mode),
    .edges   (edges),
    .state   (det)
  );

  // Phase detector: a pulse opens on the leading edge and closes when the
  // other edge arrives, so its width tracks the phase difference.
  always_comb begin
    up_d = pump_up;
    dn_d = pump_down;
    if (edges.ref_clk) up_d = 1'b1;
    if (edges.fb)      dn_d = 1'b1;
    if (up_d && dn_d) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
    if (!pll_active) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_up         <= 1'b0;
      pump_down       <= 1'b0;
      filter_tracking <= 1'b0;
    end else begin
      pump_up         <= up_d;
      pump_down       <= dn_d;
      filter_tracking <= trk_eff;
    end
  end

  // Base clock selector. A source change parks the output, waits for three
  // edges of both clocks so neither is cut mid-pulse, then resumes.
  // A stopped VCO would stall the hold, so its count is waived then.
  always_comb begin
    sel_d  = sel_q;
    vsel_d = vsel_q;
    xcnt_d = xcnt_q;
    vcnt_d = vcnt_q;
    base_d = base_clock_out;
    case (sel_q)
      pcg_pkg::PCG_SEL_RUN: begin
        if (want_vco != vsel_q) begin
          sel_d  = pcg_pkg::PCG_SEL_HOLD;
          xcnt_d = '0;
          vcnt_d = '0;
        end else if (vsel_q ? edges.vco : edges.xtal) begin
          base_d = !base_clock_out;
        end
      end
      pcg_pkg::PCG_SEL_HOLD: begin
        if (edges.xtal && xcnt_q != pcg_pkg::PCG_SWITCH_EDGES) begin
          xcnt_d = xcnt_q + 2'h1;
        end
        if (edges.vco && vcnt_q != pcg_pkg::PCG_SWITCH_EDGES) begin
          vcnt_d = vcnt_q + 2'h1;
        end
        if (xcnt_q == pcg_pkg::PCG_SWITCH_EDGES &&
            (vcnt_q == pcg_pkg::PCG_SWITCH_EDGES || !pll_active)) begin
          sel_d  = pcg_pkg::PCG_SEL_RUN;
          vsel_d = want_vco;
        end
      end
      default: begin
        sel_d = pcg_pkg::PCG_SEL_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q          <= pcg_pkg::PCG_SEL_RUN;
      vsel_q         <= 1'b0;
      xcnt_q         <= '0;
      vcnt_q         <= '0;
      base_clock_out <= 1'b0;
    end else begin
      sel_q          <= sel_d;
      vsel_q         <= vsel_d;
      xcnt_q         <= xcnt_d;
      vcnt_q         <= vcnt_d;
      base_clock_out <= base_d;
    end
  end

  // Register file. Writes land in the data phase; the lock change event
  // sets the flag after any clear so a simultaneous event is never lost.
  always_comb begin
    ctrl_d       = ctrl_q;
    bw_d         = bw_q;
    prog_d       = prog_q;
    wr_pend_d    = 1'b0;
    addr_d       = addr_q;
    det_locked_d = auto_mode ? det.locked : 1'b0;
    if (wr_pend_q) begin
      case (addr_q)
        pcg_pkg::PCG_ADDR_CTRL: begin
          ctrl_d[pcg_pkg::PCG_CTRL_IE] = hwdata[pcg_pkg::PCG_CTRL_IE];
          if (hwdata[pcg_pkg::PCG_CTRL_IF]) begin
            ctrl_d[pcg_pkg::PCG_CTRL_IF] = 1'b0;
          end
          // Power and source may not change together, power may not drop
          // while the VCO is chosen, and the VCO needs a running loop.
          if (hwdata[pcg_pkg::PCG_CTRL_PON] != ctrl_q[pcg_pkg::PCG_CTRL_PON]) begin
            if (!ctrl_q[pcg_pkg::PCG_CTRL_BSS] &&
                !hwdata[pcg_pkg::PCG_CTRL_BSS]) begin
              ctrl_d[pcg_pkg::PCG_CTRL_PON] = hwdata[pcg_pkg::PCG_CTRL_PON];
            end
          end else if (!hwdata[pcg_pkg::PCG_CTRL_BSS] || pll_active) begin
            ctrl_d[pcg_pkg::PCG_CTRL_BSS] = hwdata[pcg_pkg::PCG_CTRL_BSS];
          end
        end
        pcg_pkg::PCG_ADDR_BW: begin
          bw_d[pcg_pkg::PCG_BW_AUTO] = hwdata[pcg_pkg::PCG_BW_AUTO];
          if (!auto_mode) begin
            bw_d[pcg_pkg::PCG_BW_TRK] = hwdata[pcg_pkg::PCG_BW_TRK];
          end
        end
        pcg_pkg::PCG_ADDR_PROG: begin
          prog_d = hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (auto_mode) begin
      bw_d[pcg_pkg::PCG_BW_TRK] = det.tracking;
    end
    if (prog_d[3:0] == 4'h0) begin
      ctrl_d[pcg_pkg::PCG_CTRL_BSS] = 1'b0;
    end
    if (!auto_mode) begin
      ctrl_d[pcg_pkg::PCG_CTRL_IF] = 1'b0;
    end else if (det_locked_d != det_locked_q) begin
      ctrl_d[pcg_pkg::PCG_CTRL_IF] = 1'b1;
    end
    if (hsel && hready && htrans == pcg_pkg::PCG_HTRANS_NONSEQ) begin
      wr_pend_d = hwrite;
      addr_d    = haddr[9:0];
    end
  end

  // Read data is formed in the address phase and registered.
  always_comb begin
    rdata_d = hrdata;
    if (hsel && hready && htrans == pcg_pkg::PCG_HTRANS_NONSEQ && !hwrite) begin
      case (haddr[9:0])
        pcg_pkg::PCG_ADDR_CTRL: begin
          rdata_d = {24'h000000, ctrl_q[7:4], 3'h0, vsel_q};
        end
        pcg_pkg::PCG_ADDR_BW: begin
          rdata_d = {24'h000000, bw_q[7], lock_vis, bw_q[5], 5'h00};
        end
        pcg_pkg::PCG_ADDR_PROG: begin
          rdata_d = {24'h000000, prog_q};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q       <= pcg_pkg::PCG_CTRL_RST;
      bw_q         <= pcg_pkg::PCG_BW_RST;
      prog_q       <= pcg_pkg::PCG_PROG_RST;
      det_locked_q <= 1'b0;
      wr_pend_q    <= 1'b0;
      addr_q       <= '0;
      hrdata       <= 32'h00000000;
      pll_irq      <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      bw_q         <= bw_d;
      prog_q       <= prog_d;
      det_locked_q <= det_locked_d;
      wr_pend_q    <= wr_pend_d;
      addr_q       <= addr_d;
      hrdata       <= rdata_d;
      // Request stays high while the flag is set and enabled.
      pll_irq      <= ctrl_d[pcg_pkg::PCG_CTRL_IF] &&
                      ctrl_d[pcg_pkg::PCG_CTRL_IE] && bw_d[pcg_pkg::PCG_BW_AUTO];
    end
  end

endmodule : pcg_top

// [pcg_top_properties.sv]
// Purpose: Concurrent checks on the clock generator control ports.
// Assumes: Sampled clocks run slower than half of hclk.
// Notes:   Bound to every pcg_top instance below the checker.
module pcg_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       oscillator_enable_signal,
  input wire logic       crystal_amp_input,
  input wire logic       crystal_amp_output,
  input wire logic       vco_clock,
  input wire logic       crystal_clock,
  input wire logic       reference_clock,
  input wire logic       final_reference_clock,
  input wire logic       base_clock_out,
  input wire logic       pump_up,
  input wire logic       pump_down,
  input wire logic       vco_enable,
  input wire logic [3:0] vco_range
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A base clock toggle must follow a fresh edge of one source clock.
  sequence s_xtal_rise;
    crystal_clock && !$past(crystal_clock);
  endsequence
  sequence s_vco_rise;
    $past(vco_clock) && !$past(vco_clock, 2);
  endsequence

  property p_osc_gate;
    !$past(oscillator_enable_signal) |-> !crystal_clock;
  endproperty
  a_osc_gate: assert property (p_osc_gate)
    else $error("crystal clock runs while oscillator is off");
  property p_osc_amp;
    $past(oscillator_enable_signal) |->
      crystal_amp_output == !$past(crystal_amp_input);
  endproperty
  a_osc_amp: assert property (p_osc_amp)
    else $error("amplifier output does not invert its input");
  property p_osc_pass;
    crystal_clock |-> $past(crystal_amp_input);
  endproperty
  a_osc_pass: assert property (p_osc_pass)
    else $error("crystal clock high without crystal input");
  property p_ref_buf;
    reference_clock == $past(crystal_clock);
  endproperty
  a_ref_buf: assert property (p_ref_buf)
    else $error("reference clock is not the buffered crystal");
  property p_ref_final;
    final_reference_clock == reference_clock;
  endproperty
  a_ref_final: assert property (p_ref_final)
    else $error("final reference differs from reference");
  property p_pump_excl;
    !(pump_up && pump_down);
  endproperty
  a_pump_excl: assert property (p_pump_excl)
    else $error("both correction pulses active");
  // An up pulse may only open on a fresh edge of the final reference.
  property p_pump_up_src;
    $rose(pump_up) |-> $rose(final_reference_clock);
  endproperty
  a_pump_up_src: assert property (p_pump_up_src)
    else $error("up pulse opened without a reference edge");
  property p_l_zero;
    vco_range == 4'h0 |-> !vco_enable;
  endproperty
  a_l_zero: assert property (p_l_zero)
    else $error("loop enabled with range factor zero");
  property p_base_src;
    $changed(base_clock_out) |-> s_xtal_rise or s_vco_rise;
  endproperty
  a_base_src: assert property (p_base_src)
    else $error("base clock toggled without a source edge");
endmodule : pcg_chk

bind pcg_top pcg_chk pcg_chk_i (
  .hclk                     (hclk),
  .hresetn                  (hresetn),
  .oscillator_enable_signal (oscillator_enable_signal),
  .crystal_amp_input        (crystal_amp_input),
  .crystal_amp_output       (crystal_amp_output),
  .vco_clock                (vco_clock),
  .crystal_clock            (crystal_clock),
  .reference_clock          (reference_clock),
  .final_reference_clock    (final_reference_clock),
  .base_clock_out           (base_clock_out),
  .pump_up                  (pump_up),
  .pump_down                (pump_down),
  .vco_enable               (vco_enable),
  .vco_range                (vco_range)
);

// [pcg_osc_model.sv]
// Purpose: Behavioural crystal and VCO waveforms seen by the block.
// Assumes: Half periods are counted in hclk cycles, at least 2.
// Notes:   The VCO rate is set by the bench, not by the pump pulses.
module pcg_osc_model (
  input  wire logic [3:0] half_x,
  input  wire logic [3:0] half_v,
  input  wire logic       hclk,
  input  wire logic       vco_enable,
  output logic            crystal_amp_input,
  output logic            vco_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cx = 4'h0;
  logic [3:0] cv = 4'h0;
  initial crystal_amp_input = 1'b0;
  initial vco_clock = 1'b0;

  // The crystal runs free; the VCO stands still while it is disabled,
  // so a stale level can never pass for a running loop.
  always @(posedge hclk) begin
    cx <= (cx + 4'h1 >= half_x) ? 4'h0 : cx + 4'h1;
    if (cx + 4'h1 >= half_x)
      crystal_amp_input <= !crystal_amp_input;
    cv <= (!vco_enable || cv + 4'h1 >= half_v) ? 4'h0 : cv + 4'h1;
    if (!vco_enable)
      vco_clock <= 1'b0;
    else if (cv + 4'h1 >= half_v)
      vco_clock <= !vco_clock;
  end
endmodule : pcg_osc_model

// [tb_top.sv]
// Purpose: Self-checking bench of the clock generator control block.
// Assumes: Zero-wait AHB-Lite slave; small lock detector windows.
// Notes:   Crystal half period 6 cycles; VCO half period 3 locks at N 2.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN = 120;
  localparam logic [9:0] A_CT = pcg_pkg::PCG_ADDR_CTRL;
  localparam logic [9:0] A_BW = pcg_pkg::PCG_ADDR_BW;
  localparam logic [9:0] A_PG = pcg_pkg::PCG_ADDR_PROG;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc_en;
  logic        amp_in, amp_out, vco_clk, xclk, rclk, frclk, fbclk, bclk;
  logic        pup, pdn, ftrk, vco_en, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  vrange, half_x, half_v, prv;
  logic [7:0]  v;
  logic [9:0]  adr [4] = '{A_CT, A_BW, A_PG, 10'h3FC};
  int          fail_count, checks, seed, cnt [4], b0 [4], d [4];

  pcg_top #(.REF_WIN(4), .TRK_TOL(0), .UNT_TOL(1), .LCK_TOL(0),
            .UNL_TOL(1)) pcg_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .oscillator_enable_signal(osc_en),
    .crystal_amp_input(amp_in), .crystal_amp_output(amp_out),
    .vco_clock(vco_clk), .crystal_clock(xclk), .reference_clock(rclk),
    .final_reference_clock(frclk), .vco_feedback_clock(fbclk),
    .base_clock_out(bclk), .pump_up(pup), .pump_down(pdn),
    .filter_tracking(ftrk), .vco_enable(vco_en), .vco_range(vrange),
    .pll_irq(irq));
  pcg_osc_model pcg_osc_model_i (.half_x(half_x), .half_v(half_v),
    .hclk(hclk), .vco_enable(vco_en), .crystal_amp_input(amp_in),
    .vco_clock(vco_clk));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = !hclk;
  end

  // Edge counters for crystal, final reference, feedback and base clocks.
  initial cnt = '{0, 0, 0, 0};
  always @(posedge hclk) begin
    prv <= {xclk, frclk, fbclk, bclk};
    cnt[0] <= cnt[0] + int'(xclk && !prv[3]);
    cnt[1] <= cnt[1] + int'(frclk && !prv[2]);
    cnt[2] <= cnt[2] + int'(fbclk && !prv[1]);
    cnt[3] <= cnt[3] + int'(bclk != prv[0]);
  end

  task automatic end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Edge counts may be off by one because of phase at the window edges.
  task automatic near(input int got, input int exp);
    checks++;
    if (got < exp - 1 || got > exp + 1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  function automatic int rate(input int half);
    return WIN / (2 * half);
  endfunction : rate

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    chk({hresp, hreadyout}, 33'h001);
    if (hreadyout !== 1'b1)
      end_of_test();
  endtask : wait_rdy

  // One single word transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] dat);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= pcg_pkg::PCG_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic poll(input logic [9:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd[7:0] & m) !== e && n < 300);
    chk(rd[7:0] & m, e);
    if ((rd[7:0] & m) !== e)
      end_of_test();
  endtask : poll

  task automatic meas;
    b0 = cnt;
    repeat (WIN) @(posedge hclk);
    foreach (d[i])
      d[i] = cnt[i] - b0[i];
  endtask : meas

  // Main sequence: oscillator, programming, manual and automatic loops.
  initial begin
    {seed, fail_count, checks} = {32'd84580, 64'd0};
    {hresetn, hsel, hwrite, osc_en} = 4'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {half_x, half_v} = {4'h6, 4'h3};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (adr[i]) begin
      bus(1'b0, adr[i], 32'h0);
      chk(rd, 32'h0);
    end
    meas();
    chk(d[0], 32'h0);
    osc_en <= 1'b1;
    meas();
    near(d[0], rate(6));
    near(d[1], rate(6));
    near(d[3], rate(6));
    repeat (6) begin
      v = 8'($random(seed));
      bus(1'b1, A_PG, {24'h0, v});
      bus(1'b0, A_PG, 32'h0);
      chk(rd, {24'h0, v});
      chk(vrange, v[3:0]);
    end
    bus(1'b1, A_PG, 32'h20);
    bus(1'b1, A_CT, 32'h20);
    chk(vco_en, 1'b0);
    bus(1'b1, A_CT, 32'h30);
    repeat (60) @(posedge hclk);
    bus(1'b0, A_CT, 32'h0);
    chk(rd, 32'h20);
    for (int n = 0; n < 4; n++) begin
      bus(1'b1, A_PG, 32'(n * 16 + 7));
      meas();
      near(d[2], rate(3 * (n == 0 ? 1 : n)));
    end
    bus(1'b1, A_PG, 32'h27);
    bus(1'b0, A_BW, 32'h0);
    chk({ftrk, rd}, 33'h0);
    bus(1'b1, A_BW, 32'h20);
    bus(1'b0, A_BW, 32'h0);
    chk({ftrk, rd}, 33'h1_0000_0020);
    repeat (40) @(posedge hclk);
    bus(1'b1, A_CT, 32'h30);
    poll(A_CT, 8'h01, 8'h01);
    meas();
    near(d[3], rate(3));
    chk(irq, 1'b0);
    bus(1'b1, A_CT, 32'h20);
    poll(A_CT, 8'h01, 8'h00);
    bus(1'b1, A_BW, 32'h0);
    bus(1'b1, A_CT, 32'hA0);
    bus(1'b1, A_BW, 32'h80);
    poll(A_BW, 8'h40, 8'h40);
    chk({ftrk, irq}, 2'h3);
    bus(1'b1, A_BW, 32'h80);
    bus(1'b0, A_BW, 32'h0);
    chk(rd, 32'hE0);
    bus(1'b1, A_CT, 32'hE0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    bus(1'b1, A_CT, 32'hB0);
    poll(A_CT, 8'h01, 8'h01);
    half_v <= 4'h6;
    poll(A_BW, 8'h40, 8'h00);
    chk(irq, 1'b1);
    bus(1'b1, A_CT, 32'hE0);
    poll(A_CT, 8'h01, 8'h00);
    half_v <= 4'h3;
    bus(1'b1, A_BW, 32'h0);
    repeat (200) @(posedge hclk);
    bus(1'b0, A_BW, 32'h0);
    chk({irq, rd}, 33'h0);
    end_of_test();
  end
endmodule : tb_top
